//--- verilog/xcvr_map_pkg.sv
// Purpose: shared constants for the receive word map and core clock selection
// Assumes: 32-bit register bus, four channels per transceiver block
// Notes: clocks of the transceiver are carried as one-cycle enable strobes of clk
package xcvr_map_pkg;

	// ****************************************
	// register map
	// ****************************************
	localparam logic [7:0] OFF_CTRL = 8'h00;
	localparam logic [7:0] OFF_RECONF = 8'h04;
	localparam logic [7:0] OFF_STATUS = 8'h08;
	localparam logic [11:0] CTRL_RESET = 12'h000;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// ****************************************
	// configuration word fields
	// ****************************************
	localparam int CFG_W = 12;
	localparam int CFG_TX_PER_CH = 0;
	localparam int CFG_RX_OPT_LSB = 1;
	localparam int CFG_TX_CORE = 3;
	localparam int CFG_RX_CORE = 4;
	localparam int CFG_PIPE = 5;
	localparam int CFG_DIV2_LSB = 8;
	localparam int RECONF_START = 0;
	localparam int STAT_BUSY = 0;
	localparam int STAT_DONE = 1;
	localparam int STAT_ADDR_LSB = 8;
	localparam int STAT_ACT_LSB = 16;

	// receive clock options
	localparam logic [1:0] RX_SHARED_TX0 = 2'h0;
	localparam logic [1:0] RX_OWN_TX = 2'h1;

	// ****************************************
	// receive word layout, per 16-bit half
	// ****************************************
	localparam int SYM_W = 10;
	localparam int HALF_W = 16;
	localparam int POS_SYNC = 10;
	localparam int POS_DISPERR = 11;
	localparam int POS_PATTERN = 12;
	localparam int POS_RM_DEL = 13;
	localparam int POS_RM_INS = 14;
	localparam int POS_RUNDISP = 15;

	localparam logic [5:0] RECONF_LAST_DEF = 6'h3F;

	typedef enum logic [1:0] {
		SEQ_IDLE = 2'b00,
		SEQ_WALK = 2'b01,
		SEQ_APPLY = 2'b10
	} seq_t;

endpackage

//--- verilog/rx_half_map.sv
// Purpose: packs one 10-bit symbol and its status flags into a 16-bit half word
// Assumes: 20-bit interface with 10-bit serializer width
// Notes: pure combinational; the caller registers the word
module rx_half_map (
	input wire logic [9:0] sym,
	input wire logic sync,
	input wire logic disp_err,
	input wire logic pattern,
	input wire logic rm_del,
	input wire logic rm_ins,
	input wire logic [1:0] pipe_stat,
	input wire logic pipe_mode,
	input wire logic run_disp,
	output logic [15:0] half
);

	always_comb begin
		half = 16'h0000;
		half[xcvr_map_pkg::SYM_W-1:0] = sym;
		half[xcvr_map_pkg::POS_SYNC] = sync;
		half[xcvr_map_pkg::POS_DISPERR] = disp_err;
		half[xcvr_map_pkg::POS_PATTERN] = pattern;
		// pipe status reuses the rate-match flag positions
		if (pipe_mode) begin
			half[xcvr_map_pkg::POS_RM_DEL] = pipe_stat[0];
			half[xcvr_map_pkg::POS_RM_INS] = pipe_stat[1];
		end else begin
			half[xcvr_map_pkg::POS_RM_DEL] = rm_del;
			half[xcvr_map_pkg::POS_RM_INS] = rm_ins;
		end
		half[xcvr_map_pkg::POS_RUNDISP] = run_disp;
	end

endmodule // rx_half_map

//--- verilog/rx_div2.sv
// Purpose: optional divide-by-two of one receiver's serial clock strobe
// Assumes: serial_en is a one-cycle strobe of clk
// Notes: phase restarts whenever the divider is switched off
module rx_div2 (
	input wire logic clk,
	input wire logic rstn,
	input wire logic en,
	input wire logic serial_en,
	output logic out_en
);

	typedef struct packed {
		logic phase;
	} div_state_t;

	div_state_t st;
	div_state_t next_st;
	logic [1:0] since_out;

	always_comb begin
		next_st = st;
		if (!en) begin
			next_st.phase = 1'b0;
		end else if (serial_en) begin
			next_st.phase = ~st.phase;
		end
	end

	assign out_en = en ? (serial_en & st.phase) : serial_en;

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	// helper: serial strobes seen since the last output strobe
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			since_out <= 2'h0;
		end else if (!en || out_en) begin
			since_out <= 2'h0;
		end else if (serial_en && since_out != 2'h3) begin
			since_out <= since_out + 2'h1;
		end
	end

	// every passed strobe must follow exactly one swallowed one
	AST_DIV2_HALVES: assert property (@(posedge clk) disable iff (!rstn)
		(en && out_en) |-> since_out == 2'h1)
		else $error("divided strobe did not skip every other serial strobe");

endmodule // rx_div2

//--- verilog/xcvr_fabric_core.sv
// Purpose: receive word map, phase-compensation FIFO clock selection, rx /2 and reconfiguration sequencer
// Assumes: AXI4-Lite slave on clk; transceiver clocks arrive as one-cycle strobes of clk
// Notes: new clocking takes effect only at the end of a reconfiguration walk
//
// Chosen here: the address map and register access over AXI4-Lite.

module xcvr_fabric_core #(
	parameter int ADDR_W = 8,
	parameter int NCH = 4,
	parameter logic [5:0] RECONF_LAST = xcvr_map_pkg::RECONF_LAST_DEF
) (
	input wire logic clk,
	input wire logic rstn,
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic rx_in_valid,
	input wire logic [19:0] rx_symbol,
	input wire logic [1:0] rx_sync,
	input wire logic [1:0] rx_disp_err,
	input wire logic [1:0] rx_pattern,
	input wire logic [1:0] rx_rm_deleted,
	input wire logic [1:0] rx_rm_inserted,
	input wire logic [3:0] rx_pipe_status,
	input wire logic [1:0] rx_running_disp,
	output logic [31:0] rx_word,
	output logic rx_word_valid,
	input wire logic [NCH-1:0] rx_serial_en,
	input wire logic [NCH-1:0] tx_clkout_en,
	input wire logic [NCH-1:0] tx_coreclk_en,
	input wire logic [NCH-1:0] rx_coreclk_en,
	output logic [NCH-1:0] rx_clkout_en,
	output logic [NCH-1:0] tx_fifo_wr_en,
	output logic [NCH-1:0] rx_fifo_rd_en,
	output logic reconfig_address_en,
	output logic [5:0] reconfig_address_out,
	output logic channel_reconfig_done,
	output logic busy
);

	localparam int CW = xcvr_map_pkg::CFG_W;

	typedef struct packed {
		logic aw_held;
		logic w_held;
		logic [ADDR_W-1:0] awaddr;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
		logic [CW-1:0] pend;
		logic [CW-1:0] act;
		logic done_flag;
		xcvr_map_pkg::seq_t seq;
		logic [5:0] addr;
		logic done_pulse;
		logic [31:0] word;
		logic word_valid;
		logic [NCH-1:0] tx_en;
		logic [NCH-1:0] rx_en;
	} core_state_t;

	core_state_t st;
	core_state_t next_st;
	logic [31:0] mapped;
	logic [NCH-1:0] div_out;

	// ****************************************
	// receive word map
	// ****************************************
	genvar g;
	generate
		for (g = 0; g < 2; g++) begin : g_half
			rx_half_map u_half (
				.sym(rx_symbol[g*10 +: 10]),
				.sync(rx_sync[g]),
				.disp_err(rx_disp_err[g]),
				.pattern(rx_pattern[g]),
				.rm_del(rx_rm_deleted[g]),
				.rm_ins(rx_rm_inserted[g]),
				.pipe_stat(rx_pipe_status[g*2 +: 2]),
				.pipe_mode(st.act[xcvr_map_pkg::CFG_PIPE]),
				.run_disp(rx_running_disp[g]),
				.half(mapped[g*16 +: 16])
			);
		end
		// ****************************************
		// per-receiver divide by two
		// ****************************************
		for (g = 0; g < NCH; g++) begin : g_div
			rx_div2 u_div (
				.clk(clk),
				.rstn(rstn),
				.en(st.act[xcvr_map_pkg::CFG_DIV2_LSB + g]),
				.serial_en(rx_serial_en[g]),
				.out_en(div_out[g])
			);
		end
	endgenerate

	assign rx_clkout_en = div_out;

	// ****************************************
	// bus slave, sequencer and clock selection
	// ****************************************
	logic aw_hs;
	logic w_hs;
	logic ar_hs;
	logic [ADDR_W-1:0] wa;
	logic [31:0] wd;
	logic [3:0] ws;
	logic [CW-1:0] mask;

	assign s_axi_awready = !st.aw_held && !st.bvalid;
	assign s_axi_wready = !st.w_held && !st.bvalid;
	assign s_axi_arready = !st.rvalid;
	assign aw_hs = s_axi_awvalid && s_axi_awready;
	assign w_hs = s_axi_wvalid && s_axi_wready;
	assign ar_hs = s_axi_arvalid && s_axi_arready;
	assign wa = st.aw_held ? st.awaddr : s_axi_awaddr;
	assign wd = st.w_held ? st.wdata : s_axi_wdata;
	assign ws = st.w_held ? st.wstrb : s_axi_wstrb;
	assign mask = {{4{ws[1]}}, {8{ws[0]}}};

	always_comb begin
		next_st = st;
		next_st.done_pulse = 1'b0;
		if (st.bvalid && s_axi_bready) begin
			next_st.bvalid = 1'b0;
		end
		if (st.rvalid && s_axi_rready) begin
			next_st.rvalid = 1'b0;
		end
		if (aw_hs) begin
			next_st.aw_held = 1'b1;
			next_st.awaddr = s_axi_awaddr;
		end
		if (w_hs) begin
			next_st.w_held = 1'b1;
			next_st.wdata = s_axi_wdata;
			next_st.wstrb = s_axi_wstrb;
		end
		// sequencer; its done flag set is applied after the status clear below
		case (st.seq)
			xcvr_map_pkg::SEQ_WALK: begin
				if (st.addr == RECONF_LAST) begin
					next_st.seq = xcvr_map_pkg::SEQ_APPLY;
				end else begin
					next_st.addr = st.addr + 6'h01;
				end
			end
			xcvr_map_pkg::SEQ_APPLY: begin
				next_st.act = st.pend;
				next_st.done_pulse = 1'b1;
				next_st.seq = xcvr_map_pkg::SEQ_IDLE;
			end
			default: begin
				next_st.seq = xcvr_map_pkg::SEQ_IDLE;
			end
		endcase
		// write takes effect once both address and data are in hand
		if ((st.aw_held || aw_hs) && (st.w_held || w_hs)) begin
			next_st.aw_held = 1'b0;
			next_st.w_held = 1'b0;
			next_st.bvalid = 1'b1;
			next_st.bresp = xcvr_map_pkg::RESP_OKAY;
			if (wa == xcvr_map_pkg::OFF_CTRL) begin
				next_st.pend = (st.pend & ~mask) | (wd[CW-1:0] & mask);
			end else if (wa == xcvr_map_pkg::OFF_RECONF) begin
				// start is ignored while a walk is already running
				if (ws[0] && wd[xcvr_map_pkg::RECONF_START] && st.seq == xcvr_map_pkg::SEQ_IDLE) begin
					next_st.seq = xcvr_map_pkg::SEQ_WALK;
					next_st.addr = 6'h00;
				end
			end else if (wa == xcvr_map_pkg::OFF_STATUS) begin
				if (ws[0] && wd[xcvr_map_pkg::STAT_DONE]) begin
					next_st.done_flag = 1'b0;
				end
			end else begin
				next_st.bresp = xcvr_map_pkg::RESP_SLVERR;
			end
		end
		// a finishing walk wins over a clear in the same cycle
		if (st.seq == xcvr_map_pkg::SEQ_APPLY) begin
			next_st.done_flag = 1'b1;
		end
		if (ar_hs) begin
			next_st.rvalid = 1'b1;
			next_st.rresp = xcvr_map_pkg::RESP_OKAY;
			next_st.rdata = 32'h0000_0000;
			if (s_axi_araddr == xcvr_map_pkg::OFF_CTRL) begin
				next_st.rdata[CW-1:0] = st.pend;
			end else if (s_axi_araddr == xcvr_map_pkg::OFF_RECONF) begin
				next_st.rdata[xcvr_map_pkg::RECONF_START] = busy;
			end else if (s_axi_araddr == xcvr_map_pkg::OFF_STATUS) begin
				next_st.rdata[xcvr_map_pkg::STAT_BUSY] = busy;
				next_st.rdata[xcvr_map_pkg::STAT_DONE] = st.done_flag;
				next_st.rdata[xcvr_map_pkg::STAT_ADDR_LSB +: 6] = st.addr;
				next_st.rdata[xcvr_map_pkg::STAT_ACT_LSB +: CW] = st.act;
			end else begin
				next_st.rresp = xcvr_map_pkg::RESP_SLVERR;
			end
		end
		next_st.word_valid = rx_in_valid;
		if (rx_in_valid) begin
			next_st.word = mapped;
		end
		// FIFO clocks follow only the active configuration; the divider feeds rx only
		for (int i = 0; i < NCH; i++) begin
			if (st.act[xcvr_map_pkg::CFG_TX_CORE]) begin
				next_st.tx_en[i] = tx_coreclk_en[i];
			end else if (st.act[xcvr_map_pkg::CFG_TX_PER_CH]) begin
				next_st.tx_en[i] = tx_clkout_en[i];
			end else begin
				next_st.tx_en[i] = tx_clkout_en[0];
			end
			if (st.act[xcvr_map_pkg::CFG_RX_CORE]) begin
				next_st.rx_en[i] = rx_coreclk_en[i];
			end else if (st.act[xcvr_map_pkg::CFG_RX_OPT_LSB +: 2] == xcvr_map_pkg::RX_SHARED_TX0) begin
				next_st.rx_en[i] = tx_clkout_en[0];
			end else if (st.act[xcvr_map_pkg::CFG_RX_OPT_LSB +: 2] == xcvr_map_pkg::RX_OWN_TX) begin
				next_st.rx_en[i] = tx_clkout_en[i];
			end else begin
				next_st.rx_en[i] = div_out[i];
			end
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			st <= '0;
			st.pend <= xcvr_map_pkg::CTRL_RESET;
			st.act <= xcvr_map_pkg::CTRL_RESET;
			st.seq <= xcvr_map_pkg::SEQ_IDLE;
		end else begin
			st <= next_st;
		end
	end

	assign s_axi_bvalid = st.bvalid;
	assign s_axi_bresp = st.bresp;
	assign s_axi_rvalid = st.rvalid;
	assign s_axi_rdata = st.rdata;
	assign s_axi_rresp = st.rresp;
	assign rx_word = st.word;
	assign rx_word_valid = st.word_valid;
	assign tx_fifo_wr_en = st.tx_en;
	assign rx_fifo_rd_en = st.rx_en;
	assign reconfig_address_en = (st.seq == xcvr_map_pkg::SEQ_WALK);
	assign reconfig_address_out = st.addr;
	assign channel_reconfig_done = st.done_pulse;
	assign busy = (st.seq != xcvr_map_pkg::SEQ_IDLE);

	// ****************************************
	// checks
	// ****************************************
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);

	AST_SYMBOLS: assert property (rx_in_valid |=> rx_word[9:0] == $past(rx_symbol[9:0])
		&& rx_word[25:16] == $past(rx_symbol[19:10]))
		else $error("symbols misplaced in receive word");
	AST_SYNC: assert property (rx_in_valid |=> rx_word[10] == $past(rx_sync[0]) && rx_word[26] == $past(rx_sync[1]))
		else $error("sync flags misplaced");
	AST_DISPERR: assert property (rx_in_valid |=> {rx_word[27], rx_word[11]} == $past(rx_disp_err))
		else $error("disparity error flags misplaced");
	AST_PATTERN: assert property (rx_in_valid |=> {rx_word[28], rx_word[12]} == $past(rx_pattern))
		else $error("pattern detect flags misplaced");
	AST_RM_DEL: assert property ((rx_in_valid && !st.act[xcvr_map_pkg::CFG_PIPE])
		|=> {rx_word[29], rx_word[13]} == $past(rx_rm_deleted))
		else $error("deletion flags misplaced");
	AST_RM_INS: assert property ((rx_in_valid && !st.act[xcvr_map_pkg::CFG_PIPE])
		|=> {rx_word[30], rx_word[14]} == $past(rx_rm_inserted))
		else $error("insertion flags misplaced");
	AST_RUNDISP: assert property (rx_in_valid |=> {rx_word[31], rx_word[15]} == $past(rx_running_disp))
		else $error("running disparity misplaced");
	AST_TX_SHARED: assert property ((st.act[xcvr_map_pkg::CFG_TX_CORE +: 1] == 1'b0
		&& !st.act[xcvr_map_pkg::CFG_TX_PER_CH] && $stable(st.act)) |=> tx_fifo_wr_en == {NCH{$past(tx_clkout_en[0])}})
		else $error("shared transmit clock not from channel 0");
	AST_TX_CORE: assert property ((st.act[xcvr_map_pkg::CFG_TX_CORE] && $stable(st.act))
		|=> tx_fifo_wr_en == $past(tx_coreclk_en))
		else $error("fabric transmit core clock not used");
	AST_RX_OWN: assert property ((!st.act[xcvr_map_pkg::CFG_RX_CORE] && st.act[xcvr_map_pkg::CFG_RX_OPT_LSB +: 2] == 2'h2
		&& $stable(st.act)) |=> rx_fifo_rd_en == $past(rx_clkout_en))
		else $error("receive read clock not the channel rx clock");
	AST_WALK: assert property ($rose(busy) |-> reconfig_address_en && reconfig_address_out == 6'h00
		##1 (reconfig_address_en && reconfig_address_out == 6'h01))
		else $error("reconfiguration walk did not start at address 0");
	AST_CFG_HOLD: assert property ((st.seq != xcvr_map_pkg::SEQ_APPLY) |=> $stable(st.act))
		else $error("clock selection changed outside reconfiguration");
	AST_DONE: assert property (channel_reconfig_done |-> !busy && st.done_flag && $past(busy))
		else $error("done without completed walk");

	COV_WRITE: cover property (st.bvalid && s_axi_bready && st.bresp == xcvr_map_pkg::RESP_OKAY);
	COV_RECONF: cover property (channel_reconfig_done);
	COV_PIPE_WORD: cover property (rx_word_valid && st.act[xcvr_map_pkg::CFG_PIPE]);

endmodule // xcvr_fabric_core

//--- test/fabric_partner.sv
// Purpose: fabric-side clock strobe source for the core clock selection
// Assumes: all strobes are one-cycle enables of clk
// Notes: the sources one channel selects between differ in period or phase so the selected one can be told apart
module fabric_partner #(
	parameter int NCH = 4
) (
	input wire logic clk,
	output logic [NCH-1:0] tx_clkout_en,
	output logic [NCH-1:0] tx_coreclk_en,
	output logic [NCH-1:0] rx_coreclk_en,
	output logic [NCH-1:0] rx_serial_en
);
	timeunit 1ns;
	timeprecision 1ps;

	// ****************************************
	// strobe generation
	// ****************************************
	int cnt = 0;

	// each channel runs at its own rate, so sharing channel 0 can be told apart
	always @(posedge clk) begin
		cnt <= cnt + 1;
		for (int i = 0; i < NCH; i++) begin
			tx_clkout_en[i] <= (cnt % (2 + i)) == 0;
			tx_coreclk_en[i] <= (cnt % (2 + i)) == 1; // same rate, other phase
			rx_serial_en[i] <= (cnt % (3 + i)) == 0;
			rx_coreclk_en[i] <= (cnt % (3 + i)) == 2; // same rate, other phase
		end
	end
endmodule // fabric_partner

//--- test/tb.sv
// Purpose: self-checking bench for the receive word map and core clock selection
// Assumes: AXI4-Lite master on clk, short reconfiguration walk
// Notes: a negedge monitor predicts every registered strobe from the previous cycle
module tb;
	timeunit 1ns;
	timeprecision 1ps;

	localparam logic [5:0] LAST = 6'h07;
	logic clk, rstn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, rx_in_valid, rx_word_valid;
	logic reconfig_address_en, channel_reconfig_done, busy;
	logic [7:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, rx_word, rd_d;
	logic [3:0] s_axi_wstrb, rx_pipe_status, rx_serial_en, tx_clkout_en, tx_coreclk_en, rx_coreclk_en;
	logic [3:0] rx_clkout_en, tx_fifo_wr_en, rx_fifo_rd_en;
	logic [1:0] s_axi_bresp, s_axi_rresp, rx_sync, rx_disp_err, rx_pattern, rx_rm_deleted, rx_rm_inserted;
	logic [1:0] rx_running_disp, resp;
	logic [19:0] rx_symbol;
	logic [5:0] reconfig_address_out;
	int bad_count = 0;
	int n_compared = 0;
	int done_cnt = 0;
	int walk = 0;
	int mi;
	logic [11:0] cfg = '0;
	logic [11:0] pend = '0;
	logic [3:0] ph = '0;
	logic [3:0] prev_tx = '0;
	logic [3:0] prev_rx = '0;
	logic [3:0] er;
	logic prev_v = 1'b0;
	logic [31:0] prev_w = '0;
	logic [11:0] cfgs [8] = '{12'h000, 12'h003, 12'h005, 12'h007, 12'h018, 12'h020, 12'hA05, 12'hF06};

	xcvr_fabric_core #(.ADDR_W(8), .NCH(4), .RECONF_LAST(LAST)) u_dut (
		.clk, .rstn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
		.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
		.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
		.rx_in_valid, .rx_symbol, .rx_sync, .rx_disp_err, .rx_pattern, .rx_rm_deleted, .rx_rm_inserted,
		.rx_pipe_status, .rx_running_disp, .rx_word, .rx_word_valid, .rx_serial_en, .tx_clkout_en,
		.tx_coreclk_en, .rx_coreclk_en, .rx_clkout_en, .tx_fifo_wr_en, .rx_fifo_rd_en,
		.reconfig_address_en, .reconfig_address_out, .channel_reconfig_done, .busy);

	fabric_partner #(.NCH(4)) u_partner (.clk, .tx_clkout_en, .tx_coreclk_en, .rx_coreclk_en, .rx_serial_en);

	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	// ****************************************
	// checking and closing
	// ****************************************
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			bad_count++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic finish_test();
		if (bad_count == 0 && n_compared > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	task automatic timeout();
		bad_count++;
		finish_test();
	endtask

	function automatic logic [15:0] map_half(input logic [9:0] s, input logic sy, dp, pt, dl, ins, rd,
		input logic [1:0] ps, input logic pipe);
		return {rd, pipe ? ps[1] : ins, pipe ? ps[0] : dl, pt, dp, sy, s};
	endfunction

	// ****************************************
	// register bus master
	// ****************************************
	// handshakes sampled at negedge: nothing the bench drives moves before the next rising edge
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		logic aw_t, w_t, b_t;
		r = 2'h3;
		@(posedge clk);
		s_axi_awaddr <= a;
		s_axi_awvalid <= 1'b1;
		s_axi_wdata <= d;
		s_axi_wstrb <= 4'hF;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		for (int n = 0; n < 50; n++) begin
			@(negedge clk);
			aw_t = s_axi_awvalid && s_axi_awready;
			w_t = s_axi_wvalid && s_axi_wready;
			b_t = s_axi_bvalid && s_axi_bready;
			if (b_t) r = s_axi_bresp;
			@(posedge clk);
			if (aw_t) s_axi_awvalid <= 1'b0;
			if (w_t) s_axi_wvalid <= 1'b0;
			if (b_t) begin
				s_axi_bready <= 1'b0;
				return;
			end
		end
		timeout();
	endtask

	task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		logic ar_t, r_t;
		r = 2'h3;
		d = '0;
		@(posedge clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		for (int n = 0; n < 50; n++) begin
			@(negedge clk);
			ar_t = s_axi_arvalid && s_axi_arready;
			r_t = s_axi_rvalid && s_axi_rready;
			if (r_t) begin
				r = s_axi_rresp;
				d = s_axi_rdata;
			end
			@(posedge clk);
			if (ar_t) s_axi_arvalid <= 1'b0;
			if (r_t) begin
				s_axi_rready <= 1'b0;
				return;
			end
		end
		timeout();
	endtask

	// ****************************************
	// cycle monitor
	// ****************************************
	always @(negedge clk) begin
		if (rstn === 1'b1) begin
			if (channel_reconfig_done === 1'b1) begin
				check(32'(walk), 32'(LAST) + 1);
				check(32'(busy), 32'h0);
				cfg = pend;
				done_cnt++;
				walk = 0;
			end else if (reconfig_address_en === 1'b1) begin
				check(32'(reconfig_address_out), 32'(walk));
				check(32'(busy), 32'h1);
				walk++;
			end
			check(32'(rx_word_valid), 32'(prev_v));
			if (prev_v) check(rx_word, prev_w);
			for (mi = 0; mi < 4; mi++) begin
				if (!cfg[8 + mi]) ph[mi] = 1'b0;
				er[mi] = rx_serial_en[mi] && (!cfg[8 + mi] || ph[mi]);
				if (rx_serial_en[mi] && cfg[8 + mi]) ph[mi] = !ph[mi];
			end
			check(32'(rx_clkout_en), 32'(er));
			check(32'(tx_fifo_wr_en), 32'(prev_tx));
			check(32'(rx_fifo_rd_en), 32'(prev_rx));
			for (mi = 0; mi < 4; mi++) begin
				prev_tx[mi] = cfg[3] ? tx_coreclk_en[mi] : cfg[0] ? tx_clkout_en[mi] : tx_clkout_en[0];
				prev_rx[mi] = cfg[4] ? rx_coreclk_en[mi] : (cfg[2:1] == 2'h0) ? tx_clkout_en[0] :
					(cfg[2:1] == 2'h1) ? tx_clkout_en[mi] : er[mi];
			end
			prev_v = rx_in_valid;
			prev_w = {map_half(rx_symbol[19:10], rx_sync[1], rx_disp_err[1], rx_pattern[1], rx_rm_deleted[1],
				rx_rm_inserted[1], rx_running_disp[1], rx_pipe_status[3:2], cfg[5]),
				map_half(rx_symbol[9:0], rx_sync[0], rx_disp_err[0], rx_pattern[0], rx_rm_deleted[0],
				rx_rm_inserted[0], rx_running_disp[0], rx_pipe_status[1:0], cfg[5])};
		end
	end

	// ****************************************
	// scenarios
	// ****************************************
	// old clocking must hold while the new config is only pending
	task automatic run_cfg(input logic [11:0] c, input int ci);
		int k;
		axi_wr(xcvr_map_pkg::OFF_CTRL, 32'(c), resp);
		check(32'(resp), 32'(xcvr_map_pkg::RESP_OKAY));
		axi_rd(xcvr_map_pkg::OFF_CTRL, rd_d, resp);
		check(rd_d, 32'(c));
		repeat (20) @(posedge clk);
		pend = c;
		k = done_cnt;
		axi_wr(xcvr_map_pkg::OFF_RECONF, 32'h1, resp);
		axi_wr(xcvr_map_pkg::OFF_RECONF, 32'h1, resp); // dropped while busy
		axi_rd(xcvr_map_pkg::OFF_RECONF, rd_d, resp);
		check(rd_d, 32'h1);
		for (int n = 0; n < 100 && done_cnt == k; n++) @(posedge clk);
		if (done_cnt == k) timeout();
		axi_rd(xcvr_map_pkg::OFF_STATUS, rd_d, resp);
		check(rd_d, {4'h0, c, 2'h0, LAST, 8'h02});
		axi_wr(xcvr_map_pkg::OFF_STATUS, 32'h2, resp);
		axi_rd(xcvr_map_pkg::OFF_STATUS, rd_d, resp);
		check(rd_d, {4'h0, c, 2'h0, LAST, 8'h00});
		for (int n = 0; n < 8; n++) begin
			@(posedge clk);
			rx_in_valid <= 1'b1;
			rx_symbol <= 20'((ci * 8 + n) * 29371);
			rx_sync <= 2'(n);
			rx_disp_err <= 2'(n >> 1);
			rx_pattern <= 2'(n + ci);
			rx_rm_deleted <= 2'(ci);
			rx_rm_inserted <= 2'((ci >> 1) ^ n);
			rx_pipe_status <= 4'(n * 7 + ci);
			rx_running_disp <= 2'(~n);
		end
		@(posedge clk);
		rx_in_valid <= 1'b0;
		repeat (40) @(posedge clk);
	endtask

	initial begin
		rstn = 1'b0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, rx_in_valid} = '0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
		{rx_symbol, rx_sync, rx_disp_err, rx_pattern, rx_rm_deleted, rx_rm_inserted} = '0;
		rx_pipe_status = '0;
		rx_running_disp = '0;
		repeat (20) @(posedge clk);
		rstn <= 1'b1;
		axi_rd(xcvr_map_pkg::OFF_CTRL, rd_d, resp);
		check(rd_d, 32'(xcvr_map_pkg::CTRL_RESET));
		axi_rd(xcvr_map_pkg::OFF_STATUS, rd_d, resp);
		check(rd_d, 32'h0);
		axi_wr(8'h0C, 32'hFFFF_FFFF, resp);
		check(32'(resp), 32'(xcvr_map_pkg::RESP_SLVERR));
		axi_rd(8'h0C, rd_d, resp);
		check(rd_d, 32'h0);
		check(32'(resp), 32'(xcvr_map_pkg::RESP_SLVERR));
		axi_wr(xcvr_map_pkg::OFF_CTRL, 32'hFFFF_FFFF, resp);
		axi_rd(xcvr_map_pkg::OFF_CTRL, rd_d, resp);
		check(rd_d, 32'h0000_0FFF);
		for (int ci = 0; ci < 8; ci++) run_cfg(cfgs[ci], ci);
		finish_test();
	end
endmodule // tb
